// ---- rtl/lcd_pkg.sv ----
// Package: constants and types for the segment/common LCD driver
package lcd_pkg;
   localparam int          NUM_SEG        = 22;
   localparam int          NUM_COM        = 8;
   localparam int          NUM_SHARED     = 6;
   localparam int          NUM_PINS       = 24;
   localparam logic [7:0]  ADDR_VOLT_SEL  = 8'hfc;
   localparam logic [7:0]  ADDR_CONTROL   = 8'hfd;
   localparam logic [7:0]  RESET_CONTROL  = 8'h00;
   localparam logic [7:0]  RESET_VOLT_SEL = 8'h00;
   localparam logic [3:0]  RAM_PAGE       = 4'h8;
   localparam logic [7:0]  RAM_FIRST      = 8'h30;
   localparam logic [7:0]  RAM_LAST       = 8'h45;
   localparam int          CTL_ON_BIT     = 0;
   localparam int          CTL_BIAS_LSB   = 1;
   localparam int          CTL_DUTY_LSB   = 3;
   localparam int          CTL_CLK_LSB    = 5;
   localparam int          STEP_DIV       = 4;
   localparam logic [1:0]  STEP_LAST      = 2'h3;

   typedef enum logic [1:0] {DUTY_8, DUTY_4, DUTY_3, DUTY_2} duty_type;
   typedef enum logic [1:0] {BIAS_NONE, BIAS_CAP, BIAS_INT_RES, BIAS_EXT_RES} bias_type;

   typedef struct packed {
      logic [1:0] clk_sel;
      duty_type   duty;
      bias_type   bias;
      logic       on;
   } control_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] wmask;
      logic       wr;
      logic       rd;
   } cpu_req_type;
endpackage

// ---- rtl/lcd_scan_seq.sv ----
// Common-line scan sequencer stepped by the frame clock
`timescale 1ns/1ps
module lcd_scan_seq
   import lcd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       restart,
   input  wire logic       tick,
   input  wire logic [3:0] num_com,
   output logic      [2:0] com_idx,
   output logic            phase
);
   logic [2:0] com_r;
   logic       phase_r;

   // Ascending commons, equal slices, wrap after last; two phases per slot
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         com_r   <= 3'h0;
         phase_r <= 1'b0;
      end else if (restart) begin
         com_r   <= 3'h0;
         phase_r <= 1'b0;
      end else if (tick) begin
         phase_r <= ~phase_r;
         if (phase_r) begin
            if ({1'b0, com_r} == num_com - 4'h1) begin
               com_r <= 3'h0;
            end else begin
               com_r <= com_r + 3'h1;
            end
         end
      end
   end

   assign com_idx = com_r;
   assign phase   = phase_r;
endmodule

// ---- rtl/lcd_segment_common_driver.sv ----
// LCD segment/common driver: display RAM, control registers, scan output
//
// Behaviour
// - Drive up to 128 dots: 16 segments by 8 commons at full mux.
// - Display RAM is page 8 bytes 30h..45h, CPU bit and byte accessible.
// - Segment n uses byte 30h+n; bit n of a byte belongs to common n.
// - Refresh fetches RAM by itself on the frame clock, no CPU work.
// - Segment shows the bit for the common being scanned.
// - One gives select waveform, zero gives non-select waveform.
// - Commons 2..7 double as segments 0..5; 16 segment, 2 common pins.
// - Duty picks active commons and remaining segments: 8,4,3,2 commons.
// - Control holds duty/bias, clock select, on/off and bias type.
// - Control resets to 00h: off, 1/8 duty, 128 Hz, no bias type.
// - Frame clock from watch timer clock sets the common scan rate.
// - Each control write restarts clock and duty sequencing.
// - Scanning continues when main clock stops if subclock is source.
// - Drive-voltage select register chooses level, resets to 00h.
// - Without watch timer clock there is no scanning at all.
`timescale 1ns/1ps
module lcd_segment_common_driver
   import lcd_pkg::*;
#(
   parameter int NUM_SEGMENTS = NUM_SEG,
   parameter int NUM_COMMONS  = NUM_COM
)(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire cpu_req_type       CPU_REQ,
   input  wire logic [3:0]        CPU_PAGE,
   input  wire logic              RAM_SEL,
   output logic      [7:0]        CPU_RDATA,
   input  wire logic              WATCH_TIMER_CLOCK,
   input  wire logic              WATCH_TIMER_ENABLE,
   output logic      [7:0]        COM_OUT,
   output logic      [7:0]        COM_OE_N,
   output logic      [15:0]       SEG_OUT,
   output logic      [15:0]       SEG_OE_N,
   output logic      [1:0]        LCD_BIAS_TYPE,
   output logic      [1:0]        LCD_BIAS_RATIO,
   output logic      [7:0]        LCD_DRIVE_VOLTAGE
);
   logic [7:0]  ram_r [NUM_SEGMENTS];
   logic [7:0]  lcd_display_control_r;
   logic [7:0]  lcd_drive_voltage_select_r;
   logic [7:0]  rdata_r;
   logic [1:0]  wtc_sync_r;
   logic [1:0]  wte_sync_r;
   logic        wtc_prev_r;
   logic [2:0]  fetch_com_r;
   logic        fetch_phase_r;
   logic [7:0]  frame_div_r;
   logic        frame_tick;
   logic        ctl_write;
   logic        ram_hit;
   logic [4:0]  ram_idx;
   logic [3:0]  num_com;
   logic [2:0]  com_idx;
   logic        phase;
   logic [NUM_SEGMENTS-1:0] seg_bits_r;
   logic [7:0]  com_drive;
   logic [15:0] seg_drive;
   logic [7:0]  com_oe_n;
   logic [15:0] seg_oe_n;
   logic [7:0]  frame_div_last;
   control_type ctl;

   assign ctl = control_type'(lcd_display_control_r[CTL_CLK_LSB+1:0]);

   // CPU window into display RAM on page 8
   assign ram_hit = RAM_SEL && (CPU_PAGE == RAM_PAGE) &&
                    (CPU_REQ.addr >= RAM_FIRST) && (CPU_REQ.addr <= RAM_LAST);
   assign ram_idx = 5'(CPU_REQ.addr - RAM_FIRST);
   assign ctl_write = !RAM_SEL && CPU_REQ.wr && (CPU_REQ.addr == ADDR_CONTROL);

   // Byte and bit writes through a lane mask; segment n is byte 30h+n
   generate
      for (genvar s = 0; s < NUM_SEGMENTS; s++) begin : g_ram
         always_ff @(posedge CLK or posedge RESET) begin
            if (RESET) begin
               ram_r[s] <= 8'h00;
            end else if (ram_hit && CPU_REQ.wr && (ram_idx == 5'(s))) begin
               ram_r[s] <= (ram_r[s] & ~CPU_REQ.wmask) | (CPU_REQ.wdata & CPU_REQ.wmask);
            end
         end
      end
   endgenerate

   // Control register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         lcd_display_control_r <= RESET_CONTROL;
      end else if (ctl_write) begin
         lcd_display_control_r <= (lcd_display_control_r & ~CPU_REQ.wmask) |
                                  (CPU_REQ.wdata & CPU_REQ.wmask);
      end
   end

   // Drive-voltage select register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         lcd_drive_voltage_select_r <= RESET_VOLT_SEL;
      end else if (!RAM_SEL && CPU_REQ.wr && CPU_REQ.addr == ADDR_VOLT_SEL) begin
         lcd_drive_voltage_select_r <= (lcd_drive_voltage_select_r & ~CPU_REQ.wmask) |
                                       (CPU_REQ.wdata & CPU_REQ.wmask);
      end
   end

   // Read data; unmapped locations read as zero
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rdata_r <= 8'h00;
      end else if (CPU_REQ.rd) begin
         if (ram_hit) begin
            rdata_r <= ram_r[ram_idx];
         end else if (!RAM_SEL && CPU_REQ.addr == ADDR_CONTROL) begin
            rdata_r <= lcd_display_control_r;
         end else if (!RAM_SEL && CPU_REQ.addr == ADDR_VOLT_SEL) begin
            rdata_r <= lcd_drive_voltage_select_r;
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end
   assign CPU_RDATA = rdata_r;

   // Watch timer clock and enable come from another domain
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wtc_sync_r <= 2'b00;
         wte_sync_r <= 2'b00;
         wtc_prev_r <= 1'b0;
      end else begin
         wtc_sync_r <= {wtc_sync_r[0], WATCH_TIMER_CLOCK};
         wte_sync_r <= {wte_sync_r[0], WATCH_TIMER_ENABLE};
         wtc_prev_r <= wtc_sync_r[1];
      end
   end

   // Frame clock from watch timer edges; clock select divides further.
   // Zero selection is the fastest rate; a stopped timer gives no ticks.
   always_comb begin
      case (ctl.clk_sel)
         2'h0:    frame_div_last = 8'h00;
         2'h1:    frame_div_last = 8'h01;
         2'h2:    frame_div_last = 8'h03;
         default: frame_div_last = 8'h07;
      endcase
   end

   // Needs no CPU cycles, so scanning rides through CPU idle
   // Restart on every control write
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         frame_div_r <= 8'h00;
      end else if (ctl_write) begin
         frame_div_r <= 8'h00;
      end else if (wte_sync_r[1] && wtc_sync_r[1] && !wtc_prev_r) begin
         frame_div_r <= (frame_div_r >= frame_div_last) ? 8'h00 : frame_div_r + 8'h01;
      end
   end
   assign frame_tick = wte_sync_r[1] && wtc_sync_r[1] && !wtc_prev_r &&
                       (frame_div_r >= frame_div_last) && !ctl_write;

   // Common and phase delayed to line up with the fetched bits, so no pin
   // shows a new common against old segment data
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         fetch_com_r   <= 3'h0;
         fetch_phase_r <= 1'b0;
      end else begin
         fetch_com_r   <= com_idx;
         fetch_phase_r <= phase;
      end
   end

   // Active commons per duty
   always_comb begin
      case (ctl.duty)
         DUTY_8:  num_com = 4'h8;
         DUTY_4:  num_com = 4'h4;
         DUTY_3:  num_com = 4'h3;
         default: num_com = 4'h2;
      endcase
   end

   lcd_scan_seq u_seq (
      .clk     (CLK),
      .reset   (RESET),
      .restart (ctl_write),
      .tick    (frame_tick),
      .num_com (num_com),
      .com_idx (com_idx),
      .phase   (phase)
   );

   // Autonomous fetch of the scanned bit of every byte
   generate
      for (genvar s = 0; s < NUM_SEGMENTS; s++) begin : g_fetch
         always_ff @(posedge CLK or posedge RESET) begin
            if (RESET) begin
               seg_bits_r[s] <= 1'b0;
            end else begin
               seg_bits_r[s] <= ram_r[s][com_idx];
            end
         end
      end
   endgenerate

   // Digital drive: common active level is the inverse of phase; selected segment opposes
   // it, non-selected follows it. Bias levels are made by the analog network.
   always_comb begin
      com_drive = 8'h00;
      com_oe_n  = 8'hff;
      seg_drive = 16'h0000;
      seg_oe_n  = 16'hffff;
      if (ctl.on) begin
         for (int c = 0; c < NUM_COMMONS; c++) begin
            if (c < int'(num_com)) begin
               com_oe_n[c]  = 1'b0;
               com_drive[c] = (3'(c) == fetch_com_r) ? ~fetch_phase_r : fetch_phase_r;
            end else if (c >= 2) begin
               // Shared pin works as segment c-2
               com_oe_n[c]  = 1'b0;
               com_drive[c] = seg_bits_r[c-2] ? fetch_phase_r : ~fetch_phase_r;
            end
         end
         for (int s = NUM_SHARED; s < NUM_SEGMENTS; s++) begin
            seg_oe_n[s-NUM_SHARED]  = 1'b0;
            seg_drive[s-NUM_SHARED] = seg_bits_r[s] ? fetch_phase_r : ~fetch_phase_r;
         end
      end
   end

   // Output stage; off holds all pins released
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         COM_OUT  <= 8'h00;
         COM_OE_N <= 8'hff;
         SEG_OUT  <= 16'h0000;
         SEG_OE_N <= 16'hffff;
      end else begin
         COM_OUT  <= com_drive;
         COM_OE_N <= com_oe_n;
         SEG_OUT  <= seg_drive;
         SEG_OE_N <= seg_oe_n;
      end
   end

   assign LCD_BIAS_TYPE     = ctl.bias;
   assign LCD_BIAS_RATIO    = ctl.duty;
   assign LCD_DRIVE_VOLTAGE = lcd_drive_voltage_select_r;
endmodule

// ---- tb/lcd_panel_model.sv ----
// Panel model: a dot is on wherever a driven segment and driven common differ
`timescale 1ns/1ps
module lcd_panel_model (
   input  wire logic [7:0]       com,
   input  wire logic [7:0]       com_oe_n,
   input  wire logic [15:0]      seg,
   input  wire logic [15:0]      seg_oe_n,
   output logic      [7:0][15:0] dot
);
   // Undriven lines give no voltage, so a floating pin never lights a dot
   always_comb begin
      for (int c = 0; c < 8; c++)
         dot[c] = ~seg_oe_n & {16{~com_oe_n[c]}} & (seg ^ {16{com[c]}});
   end
endmodule

// ---- tb/lcd_segment_common_driver_checker.sv ----
// Checker: port-level properties of the LCD segment/common driver
`timescale 1ns/1ps
module lcd_checker
   import lcd_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RESET,
   input wire cpu_req_type CPU_REQ,
   input wire logic        RAM_SEL,
   input wire logic [7:0]  CPU_RDATA,
   input wire logic        WATCH_TIMER_ENABLE,
   input wire logic [7:0]  COM_OUT,
   input wire logic [7:0]  COM_OE_N,
   input wire logic [15:0] SEG_OUT,
   input wire logic [15:0] SEG_OE_N,
   input wire logic [1:0]  LCD_BIAS_TYPE,
   input wire logic [1:0]  LCD_BIAS_RATIO,
   input wire logic [7:0]  LCD_DRIVE_VOLTAGE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   logic [7:0] ctl_r;
   logic [7:0] volt_r;
   logic [2:0] quiet_r;
   logic       rw;
   assign rw = CPU_REQ.wr && !RAM_SEL;
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctl_r <= 8'h00;
         volt_r <= 8'h00;
      end else if (rw && CPU_REQ.addr == ADDR_CONTROL) begin
         ctl_r <= ctl_r & ~CPU_REQ.wmask | CPU_REQ.wdata & CPU_REQ.wmask;
      end else if (rw && CPU_REQ.addr == ADDR_VOLT_SEL) begin
         volt_r <= volt_r & ~CPU_REQ.wmask | CPU_REQ.wdata & CPU_REQ.wmask;
      end
   end
   // Pins lag a control write by the output pipeline, so wait it out
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         quiet_r <= 3'h0;
      else if (rw && CPU_REQ.addr == ADDR_CONTROL)
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
   end
   property p_off; quiet_r > 3'h2 && !ctl_r[0] |-> &COM_OE_N && &SEG_OE_N; endproperty
   a_off: assert property (p_off) else $error("pins driven while display off");
   property p_on; quiet_r > 3'h2 && ctl_r[0] |-> !COM_OE_N && !SEG_OE_N; endproperty
   a_on: assert property (p_on) else $error("pin undriven while display on");
   property p_bias; LCD_BIAS_TYPE == ctl_r[2:1] && LCD_BIAS_RATIO == ctl_r[4:3]; endproperty
   a_bias: assert property (p_bias) else $error("bias outputs differ from control");
   property p_volt; LCD_DRIVE_VOLTAGE == volt_r; endproperty
   a_volt: assert property (p_volt) else $error("drive voltage differs");
   property p_rdc; CPU_REQ.rd && !rw && !RAM_SEL && CPU_REQ.addr == ADDR_CONTROL
      |=> CPU_RDATA == $past(ctl_r); endproperty
   a_rdc: assert property (p_rdc) else $error("control read back wrong");
   property p_unm; CPU_REQ.rd && !RAM_SEL && CPU_REQ.addr != ADDR_VOLT_SEL
      && CPU_REQ.addr != ADDR_CONTROL |=> CPU_RDATA == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_stop; (!WATCH_TIMER_ENABLE && !CPU_REQ.wr) [*6] |=> $stable(COM_OUT)
      && $stable(SEG_OUT); endproperty
   a_stop: assert property (p_stop) else $error("scan moved without watch timer");
   property p_hot; quiet_r > 3'h2 && ctl_r[0] && ctl_r[4:3] == 2'h0
      |-> $onehot(COM_OUT) || $onehot(~COM_OUT); endproperty
   a_hot: assert property (p_hot) else $error("not one selected common");
   property p_two; quiet_r > 3'h2 && ctl_r[0] && ctl_r[4:3] == 2'h3 |-> COM_OUT[0] != COM_OUT[1];
   endproperty
   a_two: assert property (p_two) else $error("half duty commons not opposed");
endmodule
bind lcd_segment_common_driver lcd_checker u_chk (.CLK, .RESET, .CPU_REQ, .RAM_SEL, .CPU_RDATA,
   .WATCH_TIMER_ENABLE, .COM_OUT, .COM_OE_N, .SEG_OUT, .SEG_OE_N, .LCD_BIAS_TYPE,
   .LCD_BIAS_RATIO, .LCD_DRIVE_VOLTAGE);

// ---- tb/lcd_segment_common_driver_tb.sv ----
// Self-checking bench for the LCD segment/common driver
`timescale 1ns/1ps
module lcd_segment_common_driver_tb;
   import lcd_pkg::*;
   logic             CLK = 0, RESET = 1, sel = 0, wt_clk = 0, wt_en = 1, ph;
   cpu_req_type      req = '0;
   logic [3:0]       page = 4'h0;
   logic [7:0]       rdata, com, com_oe_n, volt, ctl = 8'h00, vm = 8'h00;
   logic [15:0]      seg, seg_oe_n;
   logic [1:0]       btype, bratio;
   logic [7:0][15:0] dot;
   logic [7:0]       ram [22] = '{default: 8'h00};
   int               bad_count = 0, comparisons = 0, ncom, c, div;
   lcd_segment_common_driver u_dut (.CLK(CLK), .RESET(RESET), .CPU_REQ(req), .CPU_PAGE(page),
      .RAM_SEL(sel), .CPU_RDATA(rdata), .WATCH_TIMER_CLOCK(wt_clk), .WATCH_TIMER_ENABLE(wt_en),
      .COM_OUT(com), .COM_OE_N(com_oe_n), .SEG_OUT(seg), .SEG_OE_N(seg_oe_n),
      .LCD_BIAS_TYPE(btype), .LCD_BIAS_RATIO(bratio), .LCD_DRIVE_VOLTAGE(volt));
   lcd_panel_model u_panel (.com(com), .com_oe_n(com_oe_n), .seg(seg), .seg_oe_n(seg_oe_n),
      .dot(dot));
   always #10 CLK = ~CLK;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic s, input logic [7:0] a, d, m, input logic w);
      @(posedge CLK) sel <= s;
      page <= RAM_PAGE;
      req <= '{a, d, m, w, !w};
      @(posedge CLK) req <= '0;
      @(negedge CLK);
   endtask
   task automatic wr(input logic s, input logic [7:0] a, d, m);
      access(s, a, d, m, 1'b1);
      if (s && a >= RAM_FIRST && a <= RAM_LAST)
         ram[a - RAM_FIRST] = ram[a - RAM_FIRST] & ~m | d & m;
      if (!s && a == ADDR_CONTROL)
         ctl = ctl & ~m | d & m;
      if (!s && a == ADDR_VOLT_SEL)
         vm = vm & ~m | d & m;
   endtask
   task automatic rd(input logic s, input logic [7:0] a);
      logic [7:0] e;
      e = 8'h00;
      if (s && a >= RAM_FIRST && a <= RAM_LAST)
         e = ram[a - RAM_FIRST];
      if (!s && a == ADDR_CONTROL)
         e = ctl;
      if (!s && a == ADDR_VOLT_SEL)
         e = vm;
      access(s, a, 8'h00, 8'h00, 1'b0);
      check(rdata, e);
   endtask
   // Watch edges are slow against CLK so the synchroniser always sees them
   task automatic edge_wt;
      @(posedge CLK) wt_clk <= 1'b1;
      repeat (4) @(posedge CLK);
      wt_clk <= 1'b0;
      repeat (4) @(negedge CLK);
   endtask
   task automatic pins;
      logic [7:0]  ec;
      logic [15:0] es;
      for (int j = 0; j < 8; j++)
         ec[j] = j < ncom ? (j == c) ^ ph : ram[j - 2][c] ^ !ph;
      for (int k = 0; k < 16; k++)
         es[k] = ram[k + 6][c] ^ !ph;
      check(com, ec);
      check(seg, es);
      check(dot[c], es ^ {16{!ph}});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100us;
      bad_count++;
      end_of_test;
   end
   initial begin
      void'($urandom(12));
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      rd(0, ADDR_CONTROL);
      rd(0, ADDR_VOLT_SEL);
      check(com_oe_n, 8'hff);
      check(seg_oe_n, 16'hffff);
      check({com, seg[7:0]}, 16'h0000);
      $display("test reset done");
      // Capacitor bias first, then on; the settle wait is short, the block does not time it
      wr(0, ADDR_CONTROL, 8'h02, 8'hff);
      wr(0, ADDR_CONTROL, 8'h01, 8'h01);
      check(btype, 2'h1);
      rd(0, ADDR_CONTROL);
      wr(0, ADDR_VOLT_SEL, 8'($urandom), 8'hff);
      check(volt, vm);
      rd(0, ADDR_VOLT_SEL);
      wr(0, 8'hfe, 8'($urandom), 8'hff);
      rd(0, 8'hfe);
      $display("test registers done");
      for (int i = 0; i < 23; i++)
         wr(1, 8'(RAM_FIRST + i), 8'($urandom), 8'hff);
      wr(1, 8'h35, 8'h00, 8'h04);
      for (int i = 0; i < 23; i++)
         rd(1, 8'(RAM_FIRST + i));
      $display("test display ram done");
      for (int d = 0; d < 4; d++) begin
         ncom = d == 0 ? 8 : 5 - d;
         div = 1 << d;
         wr(0, ADDR_CONTROL, {1'b0, d[1:0], d[1:0], 2'h1, 1'b1}, 8'hff);
         check({btype, bratio}, {2'h1, d[1:0]});
         c = 0;
         ph = 1'b0;
         repeat (4) @(negedge CLK);
         pins;
         for (int e = 1; e <= 2 * ncom * div + div; e++) begin
            edge_wt;
            if (e % div == 0) begin
               ph = !ph;
               c = ph ? c : (c + 1) % ncom;
            end
            pins;
         end
      end
      $display("test scan done");
      @(posedge CLK) wt_en <= 1'b0;
      repeat (4) @(posedge CLK);
      // Enough edges that a running divider would have ticked
      repeat (div + 1) edge_wt;
      pins;
      wr(0, ADDR_CONTROL, 8'h00, 8'hff);
      repeat (4) @(negedge CLK);
      check(com_oe_n, 8'hff);
      check(seg_oe_n, 16'hffff);
      check(com, 8'h00);
      check(seg, 16'h0000);
      $display("test stop and off done");
      end_of_test;
   end
endmodule
